// ===== hw/mad_pkg.sv
// Address map constants, region and register codes for the address decoder
package mad_pkg;

  // Region codes, one bit each in the one-hot region select
  localparam int unsigned REGION_COUNT     = 9;
  localparam int unsigned RGN_IO           = 0;
  localparam int unsigned RGN_RAM          = 1;
  localparam int unsigned RGN_FLASH        = 2;
  localparam int unsigned RGN_ROM          = 3;
  localparam int unsigned RGN_SYSREG       = 4;
  localparam int unsigned RGN_PROTECT      = 5;
  localparam int unsigned RGN_VECTOR       = 6;
  localparam int unsigned RGN_RESERVED     = 7;
  localparam int unsigned RGN_UNIMPL       = 8;

  // Register codes, one bit each in the one-hot register select
  localparam int unsigned REG_COUNT        = 10;
  localparam int unsigned REG_BREAK_STATUS = 0;
  localparam int unsigned REG_RESET_CAUSE  = 1;
  localparam int unsigned REG_BREAK_FLAG   = 2;
  localparam int unsigned REG_FLASH_CTRL   = 3;
  localparam int unsigned REG_BKPT_HIGH    = 4;
  localparam int unsigned REG_BKPT_LOW     = 5;
  localparam int unsigned REG_BKPT_CTRL    = 6;
  localparam int unsigned REG_LVI          = 7;
  localparam int unsigned REG_PROTECT      = 8;
  localparam int unsigned REG_WATCHDOG     = 9;

  // Region boundaries
  localparam logic [15:0] IO_LAST          = 16'h005F;
  localparam logic [15:0] RAM_FIRST        = 16'h0060;
  localparam logic [15:0] RAM_LAST         = 16'h035F;
  localparam logic [15:0] GAP_FIRST        = 16'h0360;
  localparam logic [15:0] GAP_LAST         = 16'h7FFF;
  localparam logic [15:0] FLASH_FIRST      = 16'h8000;
  localparam logic [15:0] FLASH_LAST       = 16'hFDFF;
  localparam logic [15:0] SYSREG_FIRST     = 16'hFE00;
  localparam logic [15:0] SYSREG_LAST      = 16'hFE0F;
  localparam logic [15:0] ROM_FIRST        = 16'hFE10;
  localparam logic [15:0] ROM_LAST         = 16'hFEFF;
  localparam logic [15:0] HOLE1_FIRST      = 16'hFF00;
  localparam logic [15:0] HOLE1_LAST       = 16'hFF7D;
  localparam logic [15:0] PROTECT_ADDR     = 16'hFF7E;
  localparam logic [15:0] HOLE2_FIRST      = 16'hFF7F;
  localparam logic [15:0] HOLE2_LAST       = 16'hFFD1;
  localparam logic [15:0] VECTOR_FIRST     = 16'hFFD2;
  localparam logic [15:0] WATCHDOG_ADDR    = 16'hFFFF;

  // System register page addresses
  localparam logic [15:0] BREAK_STATUS_ADDR = 16'hFE00;
  localparam logic [15:0] RESET_CAUSE_ADDR  = 16'hFE01;
  localparam logic [15:0] RSV_FE02_ADDR     = 16'hFE02;
  localparam logic [15:0] BREAK_FLAG_ADDR   = 16'hFE03;
  localparam logic [15:0] RSV_FIRST         = 16'hFE04;
  localparam logic [15:0] RSV_LAST          = 16'hFE06;
  localparam logic [15:0] FLASH_CTRL_ALT    = 16'hFE07;
  localparam logic [15:0] FLASH_CTRL_DEF    = 16'hFE08;
  localparam logic [15:0] BKPT_HIGH_ADDR    = 16'hFE0C;
  localparam logic [15:0] BKPT_LOW_ADDR     = 16'hFE0D;
  localparam logic [15:0] BKPT_CTRL_ADDR    = 16'hFE0E;
  localparam logic [15:0] LVI_ADDR          = 16'hFE0F;

  // Per-register bit policy: read-only, write-only and reserved bits
  localparam logic [7:0] RO_MASK  [REG_COUNT] = '{8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00,
                                                  8'h00, 8'hC0, 8'h80, 8'h00, 8'h00};
  localparam logic [7:0] WO_MASK  [REG_COUNT] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                                                  8'h00, 8'h00, 8'h00, 8'h00, 8'hFF};
  localparam logic [7:0] RSV_MASK [REG_COUNT] = '{8'h00, 8'h00, 8'h7F, 8'hF0, 8'h00,
                                                  8'h00, 8'h00, 8'h0F, 8'h00, 8'h00};

  // Values after reset
  localparam logic [REGION_COUNT-1:0] REGION_RST = 9'h000;
  localparam logic [REG_COUNT-1:0]    REG_RST    = 10'h000;
  localparam logic [7:0]              BYTE_RST   = 8'h00;
  localparam logic [15:0]             ADDR_RST   = 16'h0000;

endpackage

// ===== hw/mad_bit_policy.sv
// Per-bit write and read enables for a selected high-page register
`timescale 1ns/100ps
module mad_bit_policy
(
  // Access
  input  wire logic                            valid,
  input  wire logic                            write,
  input  wire logic [mad_pkg::REG_COUNT-1:0]   reg_sel,
  // Bit enables
  output logic      [7:0]                      wr_bit_en,
  output logic      [7:0]                      rd_bit_en
);

  logic [7:0] ro_bits;
  logic [7:0] wo_bits;
  logic [7:0] rsv_bits;

  // Or together the policy of whichever register is selected
  always_comb
  begin
    ro_bits  = 8'h00;
    wo_bits  = 8'h00;
    rsv_bits = 8'h00;
    for (int r = 0; r < int'(mad_pkg::REG_COUNT); r++)
    begin
      if (reg_sel[r])
      begin
        ro_bits  = ro_bits | mad_pkg::RO_MASK[r];
        wo_bits  = wo_bits | mad_pkg::WO_MASK[r];
        rsv_bits = rsv_bits | mad_pkg::RSV_MASK[r];
      end
    end
  end

  genvar b;
  generate
    for (b = 0; b < 8; b++)
    begin : g_bit
      // Reserved bits also masked: outcome undefined, so never forwarded
      assign wr_bit_en[b] = valid & write & ~ro_bits[b] & ~rsv_bits[b]; // [R2] [R5]
      // No read strobe reaches a write-only bit
      assign rd_bit_en[b] = valid & ~write & ~wo_bits[b]; // [R3]
    end
  endgenerate

endmodule // mad_bit_policy

// ===== hw/mad_decoder.sv
// Address map decoder: region and register selects with illegal access flags
//
// How it works
// [R1] Unimplemented access flagged for illegal address reset
// [R2] Writes to read-only bits are dropped
// [R3] Reads of write-only bits cause nothing
// [R4] Master must not write reserved addresses
// [R5] Master must not write reserved bits
// [R6] 0000 to 005F selects I/O registers
// [R7] 0360 to 7FFF is unimplemented
// [R8] 8000 to FDFF selects FLASH
// [R9] FE10 to FEFF selects monitor ROM
// [R10] FF00 to FF7D is unimplemented
// [R11] FF7E selects FLASH protect register
// [R12] FF7F-FFD1 unimplemented, FFD2-FFFF vectors
// [R13] FE00, FE01, FE03 select system registers
// [R14] FE02, FE04 to FE06 are reserved
// [R15] FE0C, FE0D breakpoint address, FE0E control
// [R16] FE0F low-voltage register, FFFF watchdog
// [R17] FE08 FLASH control, FE09-FE0B unimplemented
// [R18] Illegal address reset gated by configuration
// [R19] 0060 to 035F selects RAM
// [R20] FLASH control address is a parameter
// [R21] Exactly one region per access
`timescale 1ns/100ps
module mad_decoder
#(
  parameter logic [15:0] FLASH_CTRL_ADDR = mad_pkg::FLASH_CTRL_DEF // [R20]
)
(
  // Clock, reset, enable
  input  wire logic                               clk_sys,
  input  wire logic                               rst_n,
  input  wire logic                               clk_en,
  // CPU access
  input  wire logic                               cpu_valid,
  input  wire logic                               cpu_write,
  input  wire logic [15:0]                        cpu_addr,
  input  wire logic [7:0]                         cpu_wdata,
  // Configuration
  input  wire logic                               illegal_reset_enable,
  // Decoded access
  output logic                                    access_valid_q,
  output logic                                    access_write_q,
  output logic      [15:0]                        access_addr_q,
  output logic      [7:0]                         access_wdata_q,
  output logic      [mad_pkg::REGION_COUNT-1:0]   region_sel_q,
  output logic      [mad_pkg::REG_COUNT-1:0]      reg_sel_q,
  output logic      [7:0]                         wr_bit_en_q,
  output logic      [7:0]                         rd_bit_en_q,
  // Fault events
  output logic                                    unimpl_access_q,
  output logic                                    reserved_write_q,
  output logic                                    illegal_reset_q
);

  logic [mad_pkg::REGION_COUNT-1:0] region_d;
  logic [mad_pkg::REG_COUNT-1:0]    reg_d;
  logic [7:0]                       wr_bit_en_d;
  logic [7:0]                       rd_bit_en_d;
  logic                             flash_ctrl_hit;
  logic                             flash_ctrl_other;

  // The unused FLASH control slot falls back to reserved (FE07) or unimplemented (FE08)
  assign flash_ctrl_hit   = (cpu_addr == FLASH_CTRL_ADDR); // [R20]
  assign flash_ctrl_other = (FLASH_CTRL_ADDR == mad_pkg::FLASH_CTRL_DEF) ?
                            (cpu_addr == mad_pkg::FLASH_CTRL_ALT) :
                            (cpu_addr == mad_pkg::FLASH_CTRL_DEF);

  // Region decode: a single if chain, so exactly one bit is ever set
  always_comb
  begin
    region_d = mad_pkg::REGION_RST;
    reg_d    = mad_pkg::REG_RST;
    if (cpu_addr <= mad_pkg::IO_LAST)
    begin
      region_d[mad_pkg::RGN_IO] = 1'b1; // [R6]
    end
    else if (cpu_addr >= mad_pkg::RAM_FIRST && cpu_addr <= mad_pkg::RAM_LAST)
    begin
      region_d[mad_pkg::RGN_RAM] = 1'b1; // [R19]
    end
    else if (cpu_addr >= mad_pkg::GAP_FIRST && cpu_addr <= mad_pkg::GAP_LAST)
    begin
      region_d[mad_pkg::RGN_UNIMPL] = 1'b1; // [R7]
    end
    else if (cpu_addr >= mad_pkg::FLASH_FIRST && cpu_addr <= mad_pkg::FLASH_LAST)
    begin
      region_d[mad_pkg::RGN_FLASH] = 1'b1; // [R8]
    end
    else if (cpu_addr >= mad_pkg::SYSREG_FIRST && cpu_addr <= mad_pkg::SYSREG_LAST)
    begin
      region_d[mad_pkg::RGN_SYSREG] = 1'b1;
      if (flash_ctrl_hit)
      begin
        reg_d[mad_pkg::REG_FLASH_CTRL] = 1'b1; // [R17]
      end
      else if (cpu_addr == mad_pkg::BREAK_STATUS_ADDR)
      begin
        reg_d[mad_pkg::REG_BREAK_STATUS] = 1'b1; // [R13]
      end
      else if (cpu_addr == mad_pkg::RESET_CAUSE_ADDR)
      begin
        reg_d[mad_pkg::REG_RESET_CAUSE] = 1'b1; // [R13]
      end
      else if (cpu_addr == mad_pkg::BREAK_FLAG_ADDR)
      begin
        reg_d[mad_pkg::REG_BREAK_FLAG] = 1'b1; // [R13]
      end
      else if (cpu_addr == mad_pkg::BKPT_HIGH_ADDR)
      begin
        reg_d[mad_pkg::REG_BKPT_HIGH] = 1'b1; // [R15]
      end
      else if (cpu_addr == mad_pkg::BKPT_LOW_ADDR)
      begin
        reg_d[mad_pkg::REG_BKPT_LOW] = 1'b1; // [R15]
      end
      else if (cpu_addr == mad_pkg::BKPT_CTRL_ADDR)
      begin
        reg_d[mad_pkg::REG_BKPT_CTRL] = 1'b1; // [R15]
      end
      else if (cpu_addr == mad_pkg::LVI_ADDR)
      begin
        reg_d[mad_pkg::REG_LVI] = 1'b1; // [R16]
      end
      else if (cpu_addr == mad_pkg::RSV_FE02_ADDR ||
               (cpu_addr >= mad_pkg::RSV_FIRST && cpu_addr <= mad_pkg::RSV_LAST) ||
               (flash_ctrl_other && cpu_addr == mad_pkg::FLASH_CTRL_ALT))
      begin
        region_d = mad_pkg::REGION_RST;
        region_d[mad_pkg::RGN_RESERVED] = 1'b1; // [R14]
      end
      else
      begin
        // FE09 to FE0B, and FE08 when control is moved to FE07
        region_d = mad_pkg::REGION_RST;
        region_d[mad_pkg::RGN_UNIMPL] = 1'b1; // [R17]
      end
    end
    else if (cpu_addr >= mad_pkg::ROM_FIRST && cpu_addr <= mad_pkg::ROM_LAST)
    begin
      region_d[mad_pkg::RGN_ROM] = 1'b1; // [R9]
    end
    else if (cpu_addr >= mad_pkg::HOLE1_FIRST && cpu_addr <= mad_pkg::HOLE1_LAST)
    begin
      region_d[mad_pkg::RGN_UNIMPL] = 1'b1; // [R10]
    end
    else if (cpu_addr == mad_pkg::PROTECT_ADDR)
    begin
      region_d[mad_pkg::RGN_PROTECT]  = 1'b1; // [R11]
      reg_d[mad_pkg::REG_PROTECT]     = 1'b1; // [R11]
    end
    else if (cpu_addr >= mad_pkg::HOLE2_FIRST && cpu_addr <= mad_pkg::HOLE2_LAST)
    begin
      region_d[mad_pkg::RGN_UNIMPL] = 1'b1; // [R12]
    end
    else
    begin
      // Vectors; the top byte doubles as the watchdog control register
      region_d[mad_pkg::RGN_VECTOR] = 1'b1; // [R12] [R21]
      if (cpu_addr == mad_pkg::WATCHDOG_ADDR)
      begin
        reg_d[mad_pkg::REG_WATCHDOG] = 1'b1; // [R16]
      end
    end
  end

  mad_bit_policy u_bit_policy
  (
    .valid     (cpu_valid),
    .write     (cpu_write),
    .reg_sel   (reg_d),
    .wr_bit_en (wr_bit_en_d),
    .rd_bit_en (rd_bit_en_d)
  );

  // Registered access and selects; idle cycles show no selection
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      access_valid_q <= 1'b0;
      access_write_q <= 1'b0;
      access_addr_q  <= mad_pkg::ADDR_RST;
      access_wdata_q <= mad_pkg::BYTE_RST;
      region_sel_q   <= mad_pkg::REGION_RST;
      reg_sel_q      <= mad_pkg::REG_RST;
    end
    else if (clk_en)
    begin
      access_valid_q <= cpu_valid;
      access_write_q <= cpu_valid & cpu_write;
      access_addr_q  <= cpu_addr;
      access_wdata_q <= cpu_wdata;
      region_sel_q   <= cpu_valid ? region_d : mad_pkg::REGION_RST; // [R21]
      reg_sel_q      <= cpu_valid ? reg_d : mad_pkg::REG_RST;
    end
  end

  // Bit enables: only for high-page registers, zero elsewhere
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      wr_bit_en_q <= mad_pkg::BYTE_RST;
      rd_bit_en_q <= mad_pkg::BYTE_RST;
    end
    else if (clk_en)
    begin
      wr_bit_en_q <= (reg_d != mad_pkg::REG_RST) ? wr_bit_en_d : mad_pkg::BYTE_RST; // [R2]
      rd_bit_en_q <= (reg_d != mad_pkg::REG_RST) ? rd_bit_en_d : mad_pkg::BYTE_RST; // [R3]
    end
  end

  // Fault events, one-cycle pulses per offending access
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      unimpl_access_q  <= 1'b0;
      reserved_write_q <= 1'b0;
      illegal_reset_q  <= 1'b0;
    end
    else if (clk_en)
    begin
      unimpl_access_q  <= cpu_valid & region_d[mad_pkg::RGN_UNIMPL]; // [R1]
      // Reported only; the write itself is not blocked beyond no select
      reserved_write_q <= cpu_valid & cpu_write & region_d[mad_pkg::RGN_RESERVED]; // [R4]
      illegal_reset_q  <= cpu_valid & region_d[mad_pkg::RGN_UNIMPL] & illegal_reset_enable; // [R1] [R18]
    end
  end

endmodule // mad_decoder

// ===== test/mad_decoder_props.sv
// Port checker for the address decoder
`timescale 1ns/100ps
module mad_decoder_props
#(
  parameter logic [15:0] FLASH_CTRL_ADDR = mad_pkg::FLASH_CTRL_DEF
)
(
  // Clock, reset, enable
  input wire logic                           clk_sys,
  input wire logic                           rst_n,
  input wire logic                           clk_en,
  // CPU access and configuration
  input wire logic                           cpu_valid,
  input wire logic                           cpu_write,
  input wire logic [15:0]                    cpu_addr,
  input wire logic                           illegal_reset_enable,
  // Decoded access
  input wire logic [mad_pkg::REGION_COUNT-1:0] region_sel_q,
  input wire logic [mad_pkg::REG_COUNT-1:0]  reg_sel_q,
  input wire logic [7:0]                     wr_bit_en_q,
  input wire logic [7:0]                     rd_bit_en_q,
  // Fault events
  input wire logic                           unimpl_access_q,
  input wire logic                           reserved_write_q,
  input wire logic                           illegal_reset_q
);
  // Disabled cycles hold outputs, so every trigger needs clk_en
  wire acc = clk_en & cpu_valid;
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  sequence s_gap_req;
    acc && cpu_addr inside {[16'h0360:16'h7FFF]};
  endsequence
  sequence s_pulse;
    unimpl_access_q && region_sel_q[8] ##1 !unimpl_access_q;
  endsequence
  AST_PULSE: assert property (s_gap_req ##1 clk_en && !cpu_valid |-> s_pulse)
    else $error("unimplemented pulse wrong");
  AST_IO: assert property (acc && cpu_addr <= 16'h005F |=> region_sel_q[0])
    else $error("io page not selected");
  AST_RAM: assert property (acc && cpu_addr inside {[16'h0060:16'h035F]} |=> region_sel_q[1])
    else $error("ram not selected");
  AST_FLASH: assert property (acc && cpu_addr inside {[16'h8000:16'hFDFF]} |=> region_sel_q[2])
    else $error("flash not selected");
  AST_VEC: assert property (acc && cpu_addr >= 16'hFFD2 |=> region_sel_q[6])
    else $error("vectors not selected");
  AST_FLASH_CONTROL_REG: assert property (acc && cpu_addr == FLASH_CTRL_ADDR |=> reg_sel_q[3] && region_sel_q[4])
    else $error("flash control not selected");
  AST_RO: assert property (acc && cpu_write && cpu_addr == 16'hFE01 |=> reg_sel_q[1] && !wr_bit_en_q)
    else $error("read-only bits writable");
  AST_WO: assert property (acc && !cpu_write && cpu_addr == 16'hFFFF |=> reg_sel_q[9] && !rd_bit_en_q)
    else $error("write-only bits readable");
  AST_RSV: assert property (
    acc && cpu_write && cpu_addr inside {16'hFE02, [16'hFE04:16'hFE06]} |=> reserved_write_q && region_sel_q[7])
    else $error("reserved write not flagged");
  AST_ONE: assert property (acc |=> $onehot(region_sel_q))
    else $error("region select not one-hot");
  AST_ILL: assert property (clk_en |=> illegal_reset_q == (unimpl_access_q && $past(illegal_reset_enable)))
    else $error("illegal reset gating wrong");
endmodule // mad_decoder_props
bind mad_decoder mad_decoder_props #(.FLASH_CTRL_ADDR(FLASH_CTRL_ADDR)) u_props (.clk_sys, .rst_n, .clk_en,
  .cpu_valid, .cpu_write, .cpu_addr, .illegal_reset_enable, .region_sel_q, .reg_sel_q, .wr_bit_en_q,
  .rd_bit_en_q, .unimpl_access_q, .reserved_write_q, .illegal_reset_q);

// ===== test/mad_cpu_model.sv
// CPU bus model issuing single-byte accesses
`timescale 1ns/100ps
module mad_cpu_model
(
  // Clock
  input  wire logic        clk_sys,
  // Access
  output logic             cpu_valid,
  output logic             cpu_write,
  output logic      [15:0] cpu_addr,
  output logic      [7:0]  cpu_wdata
);
  initial {cpu_valid, cpu_write, cpu_addr, cpu_wdata} = 26'h0000000;
  // Reserved places are written only when the bench asks
  task automatic put(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    {cpu_valid, cpu_write, cpu_addr, cpu_wdata} = {1'b1, w, a, d};
  endtask
  // Idle bus shows inverted values so stale ones never match
  task automatic idle();
    @(negedge clk_sys);
    {cpu_valid, cpu_write, cpu_addr, cpu_wdata} = {1'b0, ~cpu_write, ~cpu_addr, ~cpu_wdata};
  endtask
endmodule // mad_cpu_model

// ===== test/mad_decoder_test.sv
// Self-checking bench for the address decoder
`timescale 1ns/100ps
module mad_decoder_test;
  logic        clk_sys, rst_n, clk_en, illegal_reset_enable, cpu_valid, cpu_write;
  logic [15:0] cpu_addr, access_addr_q;
  logic [7:0]  cpu_wdata, wr_bit_en_q, rd_bit_en_q, access_wdata_q;
  logic        access_valid_q, access_write_q, unimpl_access_q, reserved_write_q, illegal_reset_q;
  logic [8:0]  region_sel_q, alt_region;
  logic [9:0]  reg_sel_q, alt_reg;
  int          n_errors = 0;
  int          compares = 0;
  // Address, write, region index, register index (FF none)
  logic [31:0] rows [34] = '{32'h0000_00FF, 32'h005F_00FF, 32'h0060_01FF, 32'h035F_11FF, 32'h0360_18FF,
    32'h7FFF_08FF, 32'h8000_02FF, 32'hFDFF_02FF, 32'hFE00_0400, 32'hFE01_1401, 32'hFE02_17FF, 32'hFE03_1402,
    32'hFE04_17FF, 32'hFE05_07FF, 32'hFE06_17FF, 32'hFE07_17FF, 32'hFE08_1403, 32'hFE09_08FF, 32'hFE0B_08FF,
    32'hFE0C_1404, 32'hFE0D_0405, 32'hFE0E_1406, 32'hFE0F_1407, 32'hFE0F_0407, 32'hFE10_03FF, 32'hFEFF_03FF,
    32'hFF00_08FF, 32'hFF7D_08FF, 32'hFF7E_1508, 32'hFF7F_08FF, 32'hFFD1_08FF, 32'hFFD2_06FF, 32'hFFFF_0609,
    32'hFFFF_1609};
  mad_cpu_model cpu (.clk_sys, .cpu_valid, .cpu_write, .cpu_addr, .cpu_wdata);
  mad_decoder dut (.clk_sys, .rst_n, .clk_en, .cpu_valid, .cpu_write, .cpu_addr, .cpu_wdata,
    .illegal_reset_enable, .access_valid_q, .access_write_q, .access_addr_q, .access_wdata_q,
    .region_sel_q, .reg_sel_q, .wr_bit_en_q, .rd_bit_en_q, .unimpl_access_q, .reserved_write_q,
    .illegal_reset_q);
  // Second copy with the control register moved to its alternative slot
  mad_decoder #(.FLASH_CTRL_ADDR(mad_pkg::FLASH_CTRL_ALT)) dut_alt (.clk_sys, .rst_n, .clk_en, .cpu_valid,
    .cpu_write, .cpu_addr, .cpu_wdata, .illegal_reset_enable, .access_valid_q(), .access_write_q(),
    .access_addr_q(), .access_wdata_q(), .region_sel_q(alt_region), .reg_sel_q(alt_reg), .wr_bit_en_q(),
    .rd_bit_en_q(), .unimpl_access_q(), .reserved_write_q(), .illegal_reset_q());
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic chk_vec(input string name, input logic [15:0] exp, input logic [15:0] seen);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic chk_bit(input string name, input logic exp, input logic seen);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %b seen %b", name, exp, seen);
    end
  endtask
  // Outputs settle just after the capturing edge
  task automatic step();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic idle_chk();
    chk_vec("region", 16'h0000, 16'(region_sel_q));
    chk_vec("reg", 16'h0000, 16'(reg_sel_q));
    chk_bit("unimpl", 1'b0, unimpl_access_q);
    chk_bit("valid", 1'b0, access_valid_q);
  endtask
  task automatic results();
    if (n_errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin : main
    logic [31:0] r;
    logic [7:0]  k;
    logic        w;
    rst_n = 1'b0;
    clk_en = 1'b1;
    illegal_reset_enable = 1'b0;
    cpu.put(1'b0, 16'h7000, 8'h00);
    repeat (4) @(posedge clk_sys);
    #1;
    idle_chk();
    cpu.idle();
    rst_n = 1'b1;
    foreach (rows[i])
    begin
      r = rows[i];
      w = r[12];
      k = r[7:0];
      cpu.put(w, r[31:16], ~r[23:16]);
      illegal_reset_enable = i[0];
      step();
      chk_vec("region", 16'h0001 << r[11:8], 16'(region_sel_q));
      chk_vec("reg", (k == 8'hFF) ? 16'h0000 : 16'h0001 << k, 16'(reg_sel_q));
      chk_vec("wr_en", (k == 8'hFF || !w) ? 16'h0000 : {8'h00, ~(mad_pkg::RO_MASK[k] | mad_pkg::RSV_MASK[k])},
        {8'h00, wr_bit_en_q});
      chk_vec("rd_en", (k == 8'hFF || w) ? 16'h0000 : {8'h00, ~mad_pkg::WO_MASK[k]}, {8'h00, rd_bit_en_q});
      chk_vec("addr", r[31:16], access_addr_q);
      chk_vec("wdata", {8'h00, ~r[23:16]}, {8'h00, access_wdata_q});
      chk_bit("valid", 1'b1, access_valid_q);
      chk_bit("write", w, access_write_q);
      chk_bit("unimpl", r[11:8] == 4'h8, unimpl_access_q);
      chk_bit("rsv_wr", r[11:8] == 4'h7 && w, reserved_write_q);
      chk_bit("ill_rst", r[11:8] == 4'h8 && illegal_reset_enable, illegal_reset_q);
    end
    // Moved control slot: FE07 selects it, FE08 falls unimplemented
    cpu.put(1'b0, mad_pkg::FLASH_CTRL_ALT, 8'h00);
    step();
    chk_vec("alt_region", 16'h0010, 16'(alt_region));
    chk_vec("alt_reg", 16'h0008, 16'(alt_reg));
    cpu.put(1'b0, mad_pkg::FLASH_CTRL_DEF, 8'h00);
    step();
    chk_vec("alt_region", 16'h0100, 16'(alt_region));
    chk_vec("alt_reg", 16'h0000, 16'(alt_reg));
    cpu.idle();
    step();
    idle_chk();
    // Disabled clock holds the idle result
    cpu.put(1'b0, 16'h7000, 8'h5A);
    clk_en = 1'b0;
    illegal_reset_enable = 1'b1;
    step();
    idle_chk();
    @(negedge clk_sys);
    clk_en = 1'b1;
    step();
    chk_vec("region", 16'h0100, 16'(region_sel_q));
    chk_bit("ill_rst", 1'b1, illegal_reset_q);
    // Fault pulses last one cycle once the bus goes idle
    cpu.idle();
    step();
    idle_chk();
    chk_bit("ill_rst", 1'b0, illegal_reset_q);
    cpu.put(1'b1, 16'hFE02, 8'h00);
    rst_n = 1'b0;
    step();
    idle_chk();
    chk_bit("rsv_wr", 1'b0, reserved_write_q);
    cpu.idle();
    rst_n = 1'b1;
    step();
    idle_chk();
    results();
  end
endmodule // mad_decoder_test
